/* File: logic/commutation_pkg.sv */
// constants for the single-pwm block commutation decoder
// assumes one 25 MHz core clock; no software-visible registers
package commutation_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_FREQ_KHZ = 25000;
  // supply settle time after gate enable rises, in microseconds
  localparam int SUPPLY_SETTLE_US = 1000;
  localparam int SUPPLY_SETTLE_CYCLES =
    (SUPPLY_SETTLE_US * CLK_FREQ_KHZ + 999) / 1000;
  localparam int SYNC_STAGES = 2;

  // ****************************************************************
  // per-phase drive modes, packed {c, b, a} in the table output
  // ****************************************************************
  localparam int MODE_W = 2;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_PWM = 2'h1;
  localparam logic [1:0] MODE_LSON = 2'h2;

  // ****************************************************************
  // four-bit table index {a_low, b_high, b_low, c_high}
  // ****************************************************************
  localparam int CODE_W = 4;
  localparam logic [3:0] CODE_STOP = 4'h0;
  localparam logic [3:0] CODE_AC = 4'h2;
  localparam logic [3:0] CODE_BC_AC = 4'h3;
  localparam logic [3:0] CODE_CB = 4'h4;
  localparam logic [3:0] CODE_AB_CB = 4'h5;
  localparam logic [3:0] CODE_AB = 4'h6;
  localparam logic [3:0] CODE_AC_AB = 4'h7;
  localparam logic [3:0] CODE_BA = 4'h8;
  localparam logic [3:0] CODE_CA_BA = 4'h9;
  localparam logic [3:0] CODE_BC = 4'hA;
  localparam logic [3:0] CODE_BA_BC = 4'hB;
  localparam logic [3:0] CODE_CA = 4'hC;
  localparam logic [3:0] CODE_CB_CA = 4'hD;
  localparam logic [3:0] CODE_ALIGN = 4'hE;

  // ****************************************************************
  // synchroniser bit positions
  // ****************************************************************
  localparam int SYNC_W = 9;
  localparam int SB_PWM = 0;
  localparam int SB_CODE0 = 1;
  localparam int SB_CODE1 = 2;
  localparam int SB_CODE2 = 3;
  localparam int SB_DWELL = 4;
  localparam int SB_GATE_EN = 5;
  localparam int SB_PUMP_UV = 6;
  localparam int SB_PUMP_OV = 7;
  localparam int SB_LSD_UV = 8;

  // power sequencer states
  typedef enum logic [3:0] {
    PWR_OFF = 4'h1,
    PWR_RAMP = 4'h2,
    PWR_RUN = 4'h4,
    PWR_FAULT = 4'h8
  } pwr_state_t;

endpackage

/* File: logic/commutation_table.sv */
// block commutation lookup: four-bit code to per-phase drive mode
// assumes a registered code at the input; output is combinational
`timescale 1ns/1ps
module commutation_table (
  input wire logic [commutation_pkg::CODE_W-1:0] code,
  output logic [3*commutation_pkg::MODE_W-1:0] phase_mode
);

  // ****************************************************************
  // lookup, packed {c, b, a}
  // ****************************************************************
  function automatic logic [5:0] lookup(input logic [3:0] c);
    logic [5:0] m;
    m = {commutation_pkg::MODE_OFF, commutation_pkg::MODE_OFF,
         commutation_pkg::MODE_OFF};
    case (c)
      // six main steps
      commutation_pkg::CODE_AB:
        m = {commutation_pkg::MODE_OFF, commutation_pkg::MODE_LSON,
             commutation_pkg::MODE_PWM}; // R10
      commutation_pkg::CODE_CB:
        m = {commutation_pkg::MODE_PWM, commutation_pkg::MODE_LSON,
             commutation_pkg::MODE_OFF}; // R10
      commutation_pkg::CODE_CA:
        m = {commutation_pkg::MODE_PWM, commutation_pkg::MODE_OFF,
             commutation_pkg::MODE_LSON}; // R10
      commutation_pkg::CODE_BA:
        m = {commutation_pkg::MODE_OFF, commutation_pkg::MODE_PWM,
             commutation_pkg::MODE_LSON}; // R10
      commutation_pkg::CODE_BC:
        m = {commutation_pkg::MODE_LSON, commutation_pkg::MODE_PWM,
             commutation_pkg::MODE_OFF}; // R10
      commutation_pkg::CODE_AC:
        m = {commutation_pkg::MODE_LSON, commutation_pkg::MODE_OFF,
             commutation_pkg::MODE_PWM}; // R10
      // overlap states: union of neighbouring steps
      commutation_pkg::CODE_AB_CB:
        m = {commutation_pkg::MODE_PWM, commutation_pkg::MODE_LSON,
             commutation_pkg::MODE_PWM}; // R11
      commutation_pkg::CODE_CB_CA:
        m = {commutation_pkg::MODE_PWM, commutation_pkg::MODE_LSON,
             commutation_pkg::MODE_LSON}; // R11
      commutation_pkg::CODE_CA_BA:
        m = {commutation_pkg::MODE_PWM, commutation_pkg::MODE_PWM,
             commutation_pkg::MODE_LSON}; // R11
      commutation_pkg::CODE_BA_BC:
        m = {commutation_pkg::MODE_LSON, commutation_pkg::MODE_PWM,
             commutation_pkg::MODE_LSON}; // R11
      commutation_pkg::CODE_BC_AC:
        m = {commutation_pkg::MODE_LSON, commutation_pkg::MODE_PWM,
             commutation_pkg::MODE_PWM}; // R11
      commutation_pkg::CODE_AC_AB:
        m = {commutation_pkg::MODE_LSON, commutation_pkg::MODE_LSON,
             commutation_pkg::MODE_PWM}; // R11
      commutation_pkg::CODE_ALIGN:
        m = {commutation_pkg::MODE_LSON, commutation_pkg::MODE_LSON,
             commutation_pkg::MODE_PWM}; // R12
      // stop and unlisted codes keep everything off
      default:
        m = {commutation_pkg::MODE_OFF, commutation_pkg::MODE_OFF,
             commutation_pkg::MODE_OFF}; // R13 R19
    endcase
    return m;
  endfunction

  assign phase_mode = lookup(code);

endmodule

/* File: logic/level_sync.sv */
// two-flop synchroniser for a bus of independent levels
// assumes each bit is a slow level; no bus coherency is implied
`timescale 1ns/1ps
module level_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] stable_ff;

  // ****************************************************************
  // first stage feeds only the second stage
  // ****************************************************************
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_ff <= '0;
      stable_ff <= '0;
    end
    else
    begin
      meta_ff <= async_in;
      stable_ff <= meta_ff;
    end
  end

  assign sync_out = stable_ff;

endmodule

/* File: logic/single_pwm_block_commutation.sv */
// single-pwm input decoder and gate supply sequencer
// assumes all pins arrive from one controller and, apart from freewheel select, the unused phase c low input and
// fault clear, are resynchronised here; supply monitors are comparator levels from the analog side
`timescale 1ns/1ps

// Summary of operation
// R1: pwm on phase a high input sets duty
// R2: any duty 0 to 100 percent passes through
// R3: three select pins form the commutation code
// R4: dwell pin high holds the overlap state
// R5: controller ties dwell low if unused
// R6: phase c low input is ignored
// R7: freewheel select picks active or diode
// R8: active: low side gets inverted pwm
// R9: diode: low side held off on pwm phase
// R10: six steps: pwm, low-side on, off
// R11: overlap codes energise union of neighbours
// R12: align drives a pwm, b c low-sides
// R13: stop code holds all gates low
// R14: pump off until gate enable, then sequenced
// R15: low-side supply off until gate enable
// R16: controller waits 1 ms before switching
// R17: pump under and overvoltage monitored, reported
// R18: low-side supply undervoltage monitored, reported
// R19: unlisted codes act as stop
// R20: inputs synchronised, outputs change together; freewheel select and fault clear bypass the two-stage sync
module single_pwm_block_commutation #(
  parameter int SETTLE_CYCLES = commutation_pkg::SUPPLY_SETTLE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic phase_a_high_input,
  input wire logic phase_a_low_input,
  input wire logic phase_b_high_input,
  input wire logic phase_b_low_input,
  input wire logic phase_c_high_input,
  input wire logic phase_c_low_input,
  input wire logic freewheel_select,
  input wire logic gate_enable,
  input wire logic pump_uv_detect,
  input wire logic pump_ov_detect,
  input wire logic lsd_uv_detect,
  input wire logic fault_clear,
  output logic [2:0] high_side_gate_out,
  output logic [2:0] low_side_gate_out,
  output logic high_side_pump_enable,
  output logic low_side_supply_enable,
  output logic supplies_ready,
  output logic pump_uv_flag,
  output logic pump_ov_flag,
  output logic lsd_uv_flag
);

  localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  generate
    if (SETTLE_CYCLES < 1)
    begin : g_bad_settle
      $error("settle count must be at least one cycle");
    end
  endgenerate

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [commutation_pkg::SYNC_W-1:0] raw_in;
  logic [commutation_pkg::SYNC_W-1:0] sync_in;
  logic pwm_s;
  logic step_code_bit0;
  logic step_code_bit1;
  logic step_code_bit2;
  logic dwell_s;
  logic gate_en_s;
  logic pump_uv_s;
  logic pump_ov_s;
  logic lsd_uv_s;
  logic fw_active_ff;
  logic [commutation_pkg::CODE_W-1:0] code_ff;
  logic [commutation_pkg::CODE_W-1:0] nxt_code;
  logic pwm_ff;
  logic [3*commutation_pkg::MODE_W-1:0] phase_mode;
  commutation_pkg::pwr_state_t state_ff;
  commutation_pkg::pwr_state_t nxt_state;
  logic [CNT_W-1:0] settle_cnt_ff;
  logic [CNT_W-1:0] nxt_settle_cnt;
  logic settle_done;
  logic monitor_on;
  logic any_fault;
  logic drive_allowed;
  logic [2:0] nxt_hs;
  logic [2:0] nxt_ls;
  logic [2:0] hs_ff;
  logic [2:0] ls_ff;
  logic pump_en_ff;
  logic lsd_en_ff;
  logic ready_ff;
  logic pump_uv_ff;
  logic pump_ov_ff;
  logic lsd_uv_ff;
  logic nxt_pump_uv;
  logic nxt_pump_ov;
  logic nxt_lsd_uv;

  // ****************************************************************
  // input synchronisation
  // ****************************************************************
  // phase c low input is deliberately not sampled in this mode // R6
  assign raw_in[commutation_pkg::SB_PWM] = phase_a_high_input; // R1
  assign raw_in[commutation_pkg::SB_CODE0] = phase_a_low_input; // R3
  assign raw_in[commutation_pkg::SB_CODE1] = phase_b_high_input;
  assign raw_in[commutation_pkg::SB_CODE2] = phase_b_low_input;
  assign raw_in[commutation_pkg::SB_DWELL] = phase_c_high_input; // R4
  assign raw_in[commutation_pkg::SB_GATE_EN] = gate_enable;
  assign raw_in[commutation_pkg::SB_PUMP_UV] = pump_uv_detect;
  assign raw_in[commutation_pkg::SB_PUMP_OV] = pump_ov_detect;
  assign raw_in[commutation_pkg::SB_LSD_UV] = lsd_uv_detect;

  // every sampled pin but freewheel select and fault clear passes the same two stages, so equal skew
  level_sync #(
    .W(commutation_pkg::SYNC_W)
  ) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(raw_in),
    .sync_out(sync_in)
  ); // R20

  // named views of the synchronised bus
  assign pwm_s = sync_in[commutation_pkg::SB_PWM];
  assign step_code_bit0 = sync_in[commutation_pkg::SB_CODE0];
  assign step_code_bit1 = sync_in[commutation_pkg::SB_CODE1];
  assign step_code_bit2 = sync_in[commutation_pkg::SB_CODE2];
  assign dwell_s = sync_in[commutation_pkg::SB_DWELL];
  assign gate_en_s = sync_in[commutation_pkg::SB_GATE_EN];
  assign pump_uv_s = sync_in[commutation_pkg::SB_PUMP_UV];
  assign pump_ov_s = sync_in[commutation_pkg::SB_PUMP_OV];
  assign lsd_uv_s = sync_in[commutation_pkg::SB_LSD_UV];

  // ****************************************************************
  // commutation code and pwm capture
  // ****************************************************************
  // dwell bit is part of the index; overlap lasts while it is high
  assign nxt_code = {step_code_bit0, step_code_bit1, step_code_bit2,
                     dwell_s}; // R3 R4

  // code, pwm and freewheel choice are held together so a change
  // reaches all six gates on one edge
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      code_ff <= commutation_pkg::CODE_STOP;
      pwm_ff <= 1'b0;
      fw_active_ff <= 1'b0;
    end
    else
    begin
      code_ff <= nxt_code; // R20
      pwm_ff <= pwm_s; // R2
      fw_active_ff <= freewheel_select; // R7
    end
  end

  commutation_table u_table (
    .code(code_ff),
    .phase_mode(phase_mode)
  );

  // ****************************************************************
  // per-phase gate decode
  // ****************************************************************
  // pwm is passed level for level, so 0 and 100 percent both work
  genvar ph;
  generate
    for (ph = 0; ph < 3; ph++)
    begin : g_phase
      logic [commutation_pkg::MODE_W-1:0] mode;
      logic is_pwm;
      logic is_lson;
      assign mode = phase_mode[ph*commutation_pkg::MODE_W +:
                               commutation_pkg::MODE_W];
      assign is_pwm = (mode == commutation_pkg::MODE_PWM);
      assign is_lson = (mode == commutation_pkg::MODE_LSON);
      assign nxt_hs[ph] = drive_allowed & is_pwm & pwm_ff; // R1 R2
      // active freewheel inverts pwm onto the low side, diode holds it
      assign nxt_ls[ph] = drive_allowed &
        (is_lson | (is_pwm & fw_active_ff & ~pwm_ff)); // R8 R9
    end
  endgenerate

  // ****************************************************************
  // gate supply power-up sequencer
  // ****************************************************************
  assign settle_done = (settle_cnt_ff == CNT_W'(SETTLE_CYCLES - 1));
  assign any_fault = pump_uv_s | pump_ov_s | lsd_uv_s;
  assign monitor_on = (state_ff == commutation_pkg::PWR_RUN) |
                      (state_ff == commutation_pkg::PWR_FAULT);
  // gates only switch once both supplies have settled and are healthy
  assign drive_allowed = (state_ff == commutation_pkg::PWR_RUN) &
                         ~any_fault;

  // next state; gate enable low always returns to off
  always_comb
  begin
    nxt_state = state_ff;
    nxt_settle_cnt = settle_cnt_ff;
    case (state_ff)
      commutation_pkg::PWR_OFF:
      begin
        nxt_settle_cnt = '0;
        if (gate_en_s)
          nxt_state = commutation_pkg::PWR_RAMP; // R14 R15
      end
      commutation_pkg::PWR_RAMP:
      begin
        // monitors are ignored while the supplies ramp, except pump overvoltage, which is still flagged
        if (!gate_en_s)
          nxt_state = commutation_pkg::PWR_OFF;
        else if (settle_done)
          nxt_state = commutation_pkg::PWR_RUN; // R16
        else
          nxt_settle_cnt = settle_cnt_ff + CNT_W'(1);
      end
      commutation_pkg::PWR_RUN:
      begin
        if (!gate_en_s)
          nxt_state = commutation_pkg::PWR_OFF;
        else if (any_fault)
          nxt_state = commutation_pkg::PWR_FAULT; // R17 R18
      end
      commutation_pkg::PWR_FAULT:
      begin
        // supplies stay on; gates resume once monitors read clean
        if (!gate_en_s)
          nxt_state = commutation_pkg::PWR_OFF;
        else if (!any_fault)
          nxt_state = commutation_pkg::PWR_RUN;
      end
      default:
        nxt_state = commutation_pkg::PWR_OFF;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= commutation_pkg::PWR_OFF;
      settle_cnt_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      settle_cnt_ff <= nxt_settle_cnt;
    end
  end

  // ****************************************************************
  // sticky supply fault flags
  // ****************************************************************
  // a new detection in the clear cycle wins, so no event is lost
  assign nxt_pump_uv = (monitor_on & pump_uv_s) |
                       (pump_uv_ff & ~fault_clear); // R17
  assign nxt_pump_ov = (pump_en_ff & pump_ov_s) |
                       (pump_ov_ff & ~fault_clear); // R17
  assign nxt_lsd_uv = (monitor_on & lsd_uv_s) |
                      (lsd_uv_ff & ~fault_clear); // R18

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pump_uv_ff <= 1'b0;
      pump_ov_ff <= 1'b0;
      lsd_uv_ff <= 1'b0;
    end
    else
    begin
      pump_uv_ff <= nxt_pump_uv;
      pump_ov_ff <= nxt_pump_ov;
      lsd_uv_ff <= nxt_lsd_uv;
    end
  end

  // ****************************************************************
  // output registers
  // ****************************************************************
  // supplies follow the sequencer; both off only in the off state
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      hs_ff <= 3'h0;
      ls_ff <= 3'h0;
      pump_en_ff <= 1'b0;
      lsd_en_ff <= 1'b0;
      ready_ff <= 1'b0;
    end
    else
    begin
      hs_ff <= nxt_hs; // R20
      ls_ff <= nxt_ls; // R20
      pump_en_ff <= (nxt_state != commutation_pkg::PWR_OFF); // R14
      lsd_en_ff <= (nxt_state != commutation_pkg::PWR_OFF); // R15
      ready_ff <= (nxt_state == commutation_pkg::PWR_RUN);
    end
  end

  assign high_side_gate_out = hs_ff;
  assign low_side_gate_out = ls_ff;
  assign high_side_pump_enable = pump_en_ff;
  assign low_side_supply_enable = lsd_en_ff;
  assign supplies_ready = ready_ff;
  assign pump_uv_flag = pump_uv_ff;
  assign pump_ov_flag = pump_ov_ff;
  assign lsd_uv_flag = lsd_uv_ff;

endmodule

/* File: verif/mcu_model.sv */
// controller model driving the pwm and phase-select pins
// assumes bench commands; pins move half a period before sampling
`timescale 1ns/1ps
module mcu_model (
  input wire logic core_clk,
  input wire logic [3:0] cmd_code,
  input wire logic cmd_pwm,
  output logic pwm_pin,
  output logic [3:0] code_pins,
  output logic noise_pin
);
  // ****************************************************************
  // pin drive
  // ****************************************************************
  // known levels from time zero so nothing reaches the sync as x
  initial
  begin
    pwm_pin = 1'b0;
    code_pins = 4'h0;
    noise_pin = 1'b0;
  end

  // dwell is code bit 0; commands that do not use it keep it low
  always @(negedge core_clk)
  begin
    pwm_pin <= cmd_pwm;
    code_pins <= cmd_code;
    noise_pin <= ~noise_pin; // unused pin chatters on purpose
  end
endmodule

/* File: verif/single_pwm_block_commutation_checker.sv */
// port checker for the single-pwm commutation decoder
// assumes bind to the top module; one clock, reset active high
`timescale 1ns/1ps
module single_pwm_block_commutation_checker #(
  parameter int SETTLE_CYCLES = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic phase_a_high_input,
  input wire logic phase_a_low_input,
  input wire logic phase_b_high_input,
  input wire logic phase_b_low_input,
  input wire logic phase_c_high_input,
  input wire logic phase_c_low_input,
  input wire logic freewheel_select,
  input wire logic gate_enable,
  input wire logic pump_uv_detect,
  input wire logic pump_ov_detect,
  input wire logic lsd_uv_detect,
  input wire logic fault_clear,
  input wire logic [2:0] high_side_gate_out,
  input wire logic [2:0] low_side_gate_out,
  input wire logic high_side_pump_enable,
  input wire logic low_side_supply_enable,
  input wire logic supplies_ready,
  input wire logic pump_uv_flag,
  input wire logic pump_ov_flag,
  input wire logic lsd_uv_flag
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  logic [3:0] code4;
  logic quiet;
  logic [31:0] on_cnt_ff;
  logic [31:0] nxt_on_cnt;

  // windows use stable stretches; sync latency is not pinned exactly
  assign code4 = {phase_a_low_input, phase_b_high_input,
    phase_b_low_input, phase_c_high_input};
  assign quiet = gate_enable && supplies_ready && !pump_uv_detect
    && !pump_ov_detect && !lsd_uv_detect;
  assign nxt_on_cnt = high_side_pump_enable ? on_cnt_ff + 32'h1 : 32'h0;

  // cycles since the high-side pump came on
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      on_cnt_ff <= 32'h0;
    else
      on_cnt_ff <= nxt_on_cnt;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_stop_held;
    (code4 == 4'h0 || code4 == 4'h1 || code4 == 4'hF) [*5];
  endsequence
  sequence s_diode_steady;
    (quiet && !freewheel_select && $stable(code4)) [*5];
  endsequence
  sequence s_uv_held;
    (pump_uv_detect || lsd_uv_detect) [*6];
  endsequence

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_supply_off: assert property (!gate_enable [*4] |=>
    !high_side_pump_enable && !low_side_supply_enable)
    else $error("gate supply on while gate enable low");
  a_ready_after_settle: assert property (
    supplies_ready |-> on_cnt_ff >= SETTLE_CYCLES - 1)
    else $error("supplies ready before settle time");
  a_ready_supplies_on: assert property (supplies_ready |->
    high_side_pump_enable && low_side_supply_enable)
    else $error("ready without both gate supplies");
  a_gates_need_ready: assert property (
    (high_side_gate_out | low_side_gate_out) != 3'h0 |->
    supplies_ready || $past(supplies_ready))
    else $error("gate driven while supplies not ready");
  a_stop_gates_low: assert property (s_stop_held |=>
    high_side_gate_out == 3'h0 && low_side_gate_out == 3'h0)
    else $error("gate driven in stop code");
  a_no_cross_cond: assert property (
    (high_side_gate_out & low_side_gate_out) == 3'h0)
    else $error("high and low gate on in one phase");
  a_pwm_low_off: assert property (!phase_a_high_input [*5] |=>
    high_side_gate_out == 3'h0)
    else $error("high gate on with pwm low");
  a_diode_low_steady: assert property (s_diode_steady |=>
    $stable(low_side_gate_out))
    else $error("low gate follows pwm in diode mode");
  a_lsd_flag_set: assert property ($rose(lsd_uv_detect) &&
    supplies_ready ##1 lsd_uv_detect [*4] |=> lsd_uv_flag)
    else $error("low-side undervoltage not flagged");
  a_ov_flag_set: assert property ($rose(pump_ov_detect) &&
    high_side_pump_enable ##1 pump_ov_detect [*4] |=> pump_ov_flag)
    else $error("pump overvoltage not flagged");
  a_uv_gates_low: assert property (s_uv_held |=>
    high_side_gate_out == 3'h0 && low_side_gate_out == 3'h0)
    else $error("gate driven during undervoltage");
endmodule

bind single_pwm_block_commutation single_pwm_block_commutation_checker #(
  .SETTLE_CYCLES(SETTLE_CYCLES)
) u_chk (
  .core_clk(core_clk), .rst(rst),
  .phase_a_high_input(phase_a_high_input),
  .phase_a_low_input(phase_a_low_input),
  .phase_b_high_input(phase_b_high_input),
  .phase_b_low_input(phase_b_low_input),
  .phase_c_high_input(phase_c_high_input),
  .phase_c_low_input(phase_c_low_input),
  .freewheel_select(freewheel_select), .gate_enable(gate_enable),
  .pump_uv_detect(pump_uv_detect), .pump_ov_detect(pump_ov_detect),
  .lsd_uv_detect(lsd_uv_detect), .fault_clear(fault_clear),
  .high_side_gate_out(high_side_gate_out),
  .low_side_gate_out(low_side_gate_out),
  .high_side_pump_enable(high_side_pump_enable),
  .low_side_supply_enable(low_side_supply_enable),
  .supplies_ready(supplies_ready), .pump_uv_flag(pump_uv_flag),
  .pump_ov_flag(pump_ov_flag), .lsd_uv_flag(lsd_uv_flag)
);

/* File: verif/tb_single_pwm_block_commutation.sv */
// self-checking bench for the single-pwm commutation decoder
// assumes the controller model drives pwm and select pins
`timescale 1ns/1ps
module tb_single_pwm_block_commutation;
  localparam int SETTLE = 8;
  // per-code drive modes {c,b,a}: 0 off, 1 pwm, 2 low side held on
  localparam logic [5:0] MODES [16] = '{6'h00, 6'h00, 6'h21, 6'h25,
    6'h18, 6'h19, 6'h09, 6'h29, 6'h06, 6'h16, 6'h24, 6'h26, 6'h12,
    6'h1A, 6'h29, 6'h00};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] cmd_code = 4'h0;
  logic cmd_pwm = 1'b0;
  logic freewheel_select = 1'b1;
  logic gate_enable = 1'b0;
  logic fault_clear = 1'b0;
  logic [2:0] det = 3'h0;
  logic pwm_pin;
  logic noise_pin;
  logic [3:0] code_pins;
  logic [2:0] hs;
  logic [2:0] ls;
  logic [2:0] flag;
  logic pump_en;
  logic lsd_en;
  logic ready;
  int fail_count = 0;
  int n_tests = 0;

  // 25 MHz core clock
  always #20 core_clk = ~core_clk;

  // ****************************************************************
  // design and controller
  // ****************************************************************
  mcu_model mcu (.core_clk(core_clk), .cmd_code(cmd_code),
    .cmd_pwm(cmd_pwm), .pwm_pin(pwm_pin), .code_pins(code_pins),
    .noise_pin(noise_pin));

  single_pwm_block_commutation #(.SETTLE_CYCLES(SETTLE)) dut (
    .core_clk(core_clk), .rst(rst), .phase_a_high_input(pwm_pin),
    .phase_a_low_input(code_pins[3]), .phase_b_high_input(code_pins[2]),
    .phase_b_low_input(code_pins[1]), .phase_c_high_input(code_pins[0]),
    .phase_c_low_input(noise_pin), .freewheel_select(freewheel_select),
    .gate_enable(gate_enable), .pump_uv_detect(det[0]),
    .pump_ov_detect(det[1]), .lsd_uv_detect(det[2]),
    .fault_clear(fault_clear), .high_side_gate_out(hs),
    .low_side_gate_out(ls), .high_side_pump_enable(pump_en),
    .low_side_supply_enable(lsd_en), .supplies_ready(ready),
    .pump_uv_flag(flag[0]), .pump_ov_flag(flag[1]),
    .lsd_uv_flag(flag[2]));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic chk(input string nm, input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  // supplies stay off, then ramp; ready only after the settle count
  task automatic t_power;
    int i;
    chk("pump_en idle", {7'h0, pump_en}, 8'h0);
    chk("lsd_en idle", {7'h0, lsd_en}, 8'h0);
    gate_enable = 1'b1;
    cyc(SETTLE);
    chk("ready early", {7'h0, ready}, 8'h0);
    chk("pump_en on", {7'h0, pump_en}, 8'h1);
    chk("lsd_en on", {7'h0, lsd_en}, 8'h1);
    i = 0;
    while (ready !== 1'b1 && i < 20)
    begin
      cyc(1);
      i++;
    end
    chk("ready", {7'h0, ready}, 8'h1);
  endtask

  // every code, both freewheel modes, pwm held at 0 and 100 percent
  task automatic t_table;
    logic [1:0] m;
    logic [2:0] eh;
    logic [2:0] el;
    for (int fw = 0; fw < 2; fw++)
      for (int c = 0; c < 16; c++)
        for (int p = 0; p < 2; p++)
        begin
          freewheel_select = fw[0];
          cmd_code = c[3:0];
          cmd_pwm = p[0];
          cyc(8);
          for (int ph = 0; ph < 3; ph++)
          begin
            m = MODES[c][2*ph +: 2];
            eh[ph] = (m == 2'h1) && p[0];
            el[ph] = (m == 2'h2) || (m == 2'h1 && fw[0] && !p[0]);
          end
          chk("high gates", {5'h0, hs}, {5'h0, eh});
          chk("low gates", {5'h0, ls}, {5'h0, el});
          chk("stop gates", {2'h0, hs, ls},
            (MODES[c] == 6'h00) ? 8'h0 : {2'h0, eh, el});
        end
  endtask

  // one monitor trips mid-run; flag sticks until cleared
  task automatic t_fault(input int k);
    freewheel_select = 1'b1;
    cmd_code = 4'h6;
    cmd_pwm = 1'b1;
    cyc(8);
    det[k] = 1'b1;
    cyc(8);
    chk("flag set", {5'h0, flag}, {5'h0, 3'h1 << k});
    chk("gates in fault", {2'h0, hs, ls}, 8'h0);
    det[k] = 1'b0;
    cyc(8);
    chk("flag sticky", {5'h0, flag}, {5'h0, 3'h1 << k});
    chk("gates back", {2'h0, hs, ls}, 8'h0A);
    fault_clear = 1'b1;
    cyc(3);
    fault_clear = 1'b0;
    cyc(8);
    chk("flag cleared", {5'h0, flag}, 8'h0);
  endtask

  // dropping gate enable shuts both supplies and all gates
  task automatic t_disable;
    gate_enable = 1'b0;
    cyc(8);
    chk("pump_en off", {7'h0, pump_en}, 8'h0);
    chk("lsd_en off", {7'h0, lsd_en}, 8'h0);
    chk("ready off", {7'h0, ready}, 8'h0);
    chk("gates off", {2'h0, hs, ls}, 8'h0);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    cyc(2);
    t_power();
    t_table();
    for (int k = 0; k < 3; k++)
      t_fault(k);
    t_disable();
    close_out();
  end
endmodule
